// ===== verilog/rcsp_pkg.sv
// Package for the reader control and status page.
// Assumes a single 8-bit register port driven by the host interface logic.
package rcsp_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [5:0] ADDR_CONTROL = 6'h09;
  localparam logic [5:0] ADDR_ERRORS = 6'h0A;
  localparam logic [5:0] ADDR_CLASH = 6'h0B;
  localparam logic [5:0] ADDR_COUNT = 6'h0C;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] ERRORS_RST = 8'h40;
  localparam logic [7:0] CLASH_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;

  // ==========================================================
  // Control bit positions
  localparam int CTL_STANDBY = 5;
  localparam int CTL_SLEEP = 4;
  localparam int CTL_CIPHER = 3;
  localparam int CTL_HALT = 2;
  localparam int CTL_LAUNCH = 1;
  localparam int CTL_PURGE = 0;

  // ==========================================================
  // Error bit positions
  localparam int ERR_KEY = 6;
  localparam int ERR_RIGHTS = 5;
  localparam int ERR_OVERRUN = 4;
  localparam int ERR_CHECKSUM = 3;
  localparam int ERR_FRAME = 2;
  localparam int ERR_PARITY = 1;
  localparam int ERR_CLASH = 0;

  // ==========================================================
  // Queue fill count width
  localparam int FILL_W = 7;

  // Host register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rcsp_bus_s;

  // Events from the command, receive and queue logic
  typedef struct packed {
    logic key_load_start;
    logic key_format_bad;
    logic eeprom_cmd_start;
    logic eeprom_rights_bad;
    logic queue_write_full;
    logic receive_prepare_state;
    logic receive_checksum_check_enable;
    logic checksum_bad;
    logic sof_bad;
    logic parity_bad;
    logic clash_seen;
    logic [7:0] clash_pos;
    logic type_b_mode;
    logic auth_step_two_ok;
    logic cipher_drop;
  } rcsp_evt_s;

endpackage

// ===== verilog/rcsp_page.sv
// Control and status register page: control, error flags, clash index, timer count.
// Assumes host strobes and event pulses are synchronous to clk_sys.
//
// Behaviour
// - Control at 09h resets to zero; bits 7 and 6 reserved.
// - Writing control bit 5 enters standby; clock keeps running.
// - Writing control bit 4 enters power-down; clock stopped too.
// - Cipher bit set only by successful second authentication step; enables encryption.
// - Writing bit 2 stops the timer at once; reads as zero.
// - Writing bit 1 starts the timer at once; reads as zero.
// - Writing bit 0 purges queue pointers, fill count, overrun flag; reads zero.
// - Error flags at 0Ah are read-only, reset to 40h, last command status.
// - Key format error set on bad key data, cleared when key load starts.
// - EEPROM rights error set on violation, cleared when EEPROM command starts.
// - Overrun flag set on a write into a full queue.
// - Checksum error set when checking enabled and received checksum fails.
// - Frame error set when received start of frame is wrong.
// - Parity error set when received parity check fails.
// - Collision error set on bit collision, meaningful for type A only.
// - Checksum, frame, parity, collision errors cleared in receive prepare state.
// - Clash index at 0Bh gives bit index of first collision in frame.
// - Clash index does not report collisions in type B mode.
// - Timer count at 0Ch shows current timer value; read-only.
`timescale 1ns/10ps
module rcsp_page (
  input wire logic clk_sys,
  input wire logic rst,
  input rcsp_pkg::rcsp_bus_s bus,
  input rcsp_pkg::rcsp_evt_s evt,
  input wire logic [7:0] countdown_now,
  output logic [7:0] rdata,
  output logic standby_active,
  output logic full_sleep_request,
  output logic card_cipher_active,
  output logic counter_halt_strobe,
  output logic counter_launch_strobe,
  output logic queue_purge,
  output logic queue_overrun_flag,
  output logic [7:0] first_clash_index
);

  // ==========================================================
  // Write decode
  logic ctl_wr;
  assign ctl_wr = bus.wr && (bus.addr == rcsp_pkg::ADDR_CONTROL);

  // ==========================================================
  // Persistent control bits
  logic standby_r;
  logic sleep_r;
  logic cipher_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      standby_r <= rcsp_pkg::CONTROL_RST[rcsp_pkg::CTL_STANDBY];
      sleep_r <= rcsp_pkg::CONTROL_RST[rcsp_pkg::CTL_SLEEP];
    end else if (ctl_wr) begin
      standby_r <= bus.wdata[rcsp_pkg::CTL_STANDBY];
      sleep_r <= bus.wdata[rcsp_pkg::CTL_SLEEP];
    end
  end

  // Cipher: only authentication sets it; host may only clear it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cipher_r <= rcsp_pkg::CONTROL_RST[rcsp_pkg::CTL_CIPHER];
    end else if (evt.auth_step_two_ok) begin
      cipher_r <= 1'b1;
    end else if (evt.cipher_drop || (ctl_wr && !bus.wdata[rcsp_pkg::CTL_CIPHER])) begin
      cipher_r <= 1'b0;
    end
  end

  // ==========================================================
  // Strobes, one cycle wide
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      counter_halt_strobe <= 1'b0;
      counter_launch_strobe <= 1'b0;
      queue_purge <= 1'b0;
    end else begin
      counter_halt_strobe <= ctl_wr && bus.wdata[rcsp_pkg::CTL_HALT];
      counter_launch_strobe <= ctl_wr && bus.wdata[rcsp_pkg::CTL_LAUNCH];
      queue_purge <= ctl_wr && bus.wdata[rcsp_pkg::CTL_PURGE];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      standby_active <= 1'b0;
      full_sleep_request <= 1'b0;
      card_cipher_active <= 1'b0;
    end else begin
      standby_active <= standby_r;
      full_sleep_request <= sleep_r;
      card_cipher_active <= cipher_r;
    end
  end

  // ==========================================================
  // Error flags; a set wins over a clear in the same cycle
  logic [7:0] err_r;
  logic purge_now;
  assign purge_now = ctl_wr && bus.wdata[rcsp_pkg::CTL_PURGE];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      err_r <= rcsp_pkg::ERRORS_RST;
    end else begin
      err_r[7] <= 1'b0;
      if (evt.key_format_bad) begin
        err_r[rcsp_pkg::ERR_KEY] <= 1'b1;
      end else if (evt.key_load_start) begin
        err_r[rcsp_pkg::ERR_KEY] <= 1'b0;
      end
      if (evt.eeprom_rights_bad) begin
        err_r[rcsp_pkg::ERR_RIGHTS] <= 1'b1;
      end else if (evt.eeprom_cmd_start) begin
        err_r[rcsp_pkg::ERR_RIGHTS] <= 1'b0;
      end
      if (evt.queue_write_full) begin
        err_r[rcsp_pkg::ERR_OVERRUN] <= 1'b1;
      end else if (purge_now) begin
        err_r[rcsp_pkg::ERR_OVERRUN] <= 1'b0;
      end
      if (evt.receive_checksum_check_enable && evt.checksum_bad) begin
        err_r[rcsp_pkg::ERR_CHECKSUM] <= 1'b1;
      end else if (evt.receive_prepare_state) begin
        err_r[rcsp_pkg::ERR_CHECKSUM] <= 1'b0;
      end
      if (evt.sof_bad) begin
        err_r[rcsp_pkg::ERR_FRAME] <= 1'b1;
      end else if (evt.receive_prepare_state) begin
        err_r[rcsp_pkg::ERR_FRAME] <= 1'b0;
      end
      if (evt.parity_bad) begin
        err_r[rcsp_pkg::ERR_PARITY] <= 1'b1;
      end else if (evt.receive_prepare_state) begin
        err_r[rcsp_pkg::ERR_PARITY] <= 1'b0;
      end
      if (evt.clash_seen && !evt.type_b_mode) begin
        err_r[rcsp_pkg::ERR_CLASH] <= 1'b1;
      end else if (evt.receive_prepare_state) begin
        err_r[rcsp_pkg::ERR_CLASH] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      queue_overrun_flag <= 1'b0;
    end else begin
      queue_overrun_flag <= err_r[rcsp_pkg::ERR_OVERRUN];
    end
  end

  // ==========================================================
  // First clash index, latched once per frame
  logic [7:0] clash_r;
  logic clash_held_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clash_r <= rcsp_pkg::CLASH_RST;
      clash_held_r <= 1'b0;
    end else if (evt.receive_prepare_state) begin
      clash_held_r <= 1'b0;
    end else if (evt.clash_seen && !evt.type_b_mode && !clash_held_r) begin
      clash_r <= evt.clash_pos;
      clash_held_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      first_clash_index <= rcsp_pkg::CLASH_RST;
    end else begin
      first_clash_index <= clash_r;
    end
  end

  // ==========================================================
  // Read path; strobe bits and reserved bits read zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        rcsp_pkg::ADDR_CONTROL: rdata <= {2'b00, standby_r, sleep_r, cipher_r, 3'b000};
        rcsp_pkg::ADDR_ERRORS: rdata <= err_r;
        rcsp_pkg::ADDR_CLASH: rdata <= clash_r;
        rcsp_pkg::ADDR_COUNT: rdata <= countdown_now;
        default: rdata <= 8'h00;
      endcase
    end
  end

endmodule

// ===== test/rcsp_page_checker.sv
// Assertions on the control and status page ports.
// Assumes the page ports as declared; bound below.
`timescale 1ns/10ps
module rcsp_page_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input rcsp_pkg::rcsp_bus_s bus,
  input rcsp_pkg::rcsp_evt_s evt,
  input wire logic standby_active,
  input wire logic full_sleep_request,
  input wire logic card_cipher_active,
  input wire logic counter_halt_strobe,
  input wire logic counter_launch_strobe,
  input wire logic queue_purge,
  input wire logic queue_overrun_flag,
  input wire logic [7:0] first_clash_index
);
  // ====================
  // Properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_ctl;
    bus.wr && bus.addr == rcsp_pkg::ADDR_CONTROL;
  endsequence
  AST_STANDBY: assert property (s_ctl |=> ##1 standby_active == $past(bus.wdata[5], 2))
    else $error("standby level wrong");
  AST_SLEEP: assert property (s_ctl |=> ##1 full_sleep_request == $past(bus.wdata[4], 2))
    else $error("sleep level wrong");
  AST_HALT: assert property (s_ctl ##0 bus.wdata[2] |=> counter_halt_strobe)
    else $error("halt strobe missing");
  AST_LAUNCH: assert property (s_ctl ##0 bus.wdata[1] |=> counter_launch_strobe)
    else $error("launch strobe missing");
  AST_PURGE: assert property (s_ctl ##0 bus.wdata[0] && !evt.queue_write_full |=> queue_purge ##1 !queue_overrun_flag)
    else $error("purge wrong");
  AST_OVERRUN: assert property (evt.queue_write_full |=> ##1 queue_overrun_flag)
    else $error("overrun flag missing");
  AST_CIPHER_ON: assert property (evt.auth_step_two_ok |=> ##1 card_cipher_active)
    else $error("cipher not set");
  AST_CIPHER_SRC: assert property ($rose(card_cipher_active) |-> $past(evt.auth_step_two_ok, 2))
    else $error("cipher set without auth");
  AST_TYPE_B: assert property (evt.type_b_mode [*3] |-> $stable(first_clash_index))
    else $error("clash index moved in type B");
endmodule
bind rcsp_page rcsp_page_checker i_chk (.clk_sys(clk_sys), .rst(rst), .bus(bus), .evt(evt),
  .standby_active(standby_active), .full_sleep_request(full_sleep_request),
  .card_cipher_active(card_cipher_active), .counter_halt_strobe(counter_halt_strobe),
  .counter_launch_strobe(counter_launch_strobe), .queue_purge(queue_purge),
  .queue_overrun_flag(queue_overrun_flag), .first_clash_index(first_clash_index));

// ===== test/rcsp_host.sv
// Host model issuing register cycles on the page bus.
// Assumes the bench calls acc; drives at the falling edge.
`timescale 1ns/10ps
module rcsp_host (
  input wire logic clk_sys,
  output rcsp_pkg::rcsp_bus_s bus
);
  // ====================
  // Bus cycle
  initial bus = '0;
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    bus = {w, !w, a, d};
    @(negedge clk_sys);
    bus = {2'h0, ~a, ~d};
  endtask
endmodule

// ===== test/rcsp_page_tb_top.sv
// Self-checking bench for the control and status page.
// Assumes the host model and checker files compile first.
`timescale 1ns/10ps
module rcsp_page_tb_top;
  logic clk_sys;
  logic rst;
  rcsp_pkg::rcsp_bus_s bus;
  rcsp_pkg::rcsp_evt_s evt_lvl;
  rcsp_pkg::rcsp_evt_s evt_pul;
  logic [7:0] countdown_now;
  logic [7:0] rdata;
  logic [7:0] clash;
  logic [7:0] clash_out;
  logic rd_seen;
  logic [7:0] exp_q[$];
  int err_count = 0;
  int total_checks = 0;
  int bt[12] = '{21, 20, 21, 18, 19, 17, 14, 13, 12, 11, 16, 1};
  logic [7:0] ex[12] = '{8'h00, 8'h40, 8'h00, 8'h20, 8'h00, 8'h10, 8'h08, 8'h0C, 8'h0E,
    8'h0F, 8'h00, 8'h08};
  rcsp_host i_host (.clk_sys(clk_sys), .bus(bus));
  rcsp_page i_dut (.clk_sys(clk_sys), .rst(rst), .bus(bus), .evt(evt_lvl | evt_pul),
    .countdown_now(countdown_now), .rdata(rdata), .standby_active(), .full_sleep_request(),
    .card_cipher_active(), .counter_halt_strobe(), .counter_launch_strobe(), .queue_purge(),
    .queue_overrun_flag(), .first_clash_index(clash_out));
  // ====================
  // Clock, tasks, monitor
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.acc(1'b0, a, 8'h00);
  endtask
  task automatic ev(input int b);
    @(negedge clk_sys);
    evt_pul = rcsp_pkg::rcsp_evt_s'(22'h1 << b);
    @(negedge clk_sys);
    evt_pul = '0;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_sys) rd_seen <= bus.rd;
  always @(negedge clk_sys) begin
    if (rd_seen === 1'b1) check("rdata", rdata, exp_q.pop_front());
  end
  initial begin
    #50000;
    err_count++;
    complete_run;
  end
  // ====================
  // Scenarios
  initial begin
    rst = 1'b1;
    evt_lvl = '0;
    evt_pul = '0;
    countdown_now = 8'h00;
    void'($urandom(32'h5C75));
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    rd(rcsp_pkg::ADDR_CONTROL, 8'h00);
    rd(rcsp_pkg::ADDR_ERRORS, 8'h40);
    rd(rcsp_pkg::ADDR_CLASH, 8'h00);
    rd(6'h3F, 8'h00);
    countdown_now = 8'($urandom);
    rd(rcsp_pkg::ADDR_COUNT, countdown_now);
    i_host.acc(1'b1, rcsp_pkg::ADDR_ERRORS, 8'h00);
    rd(rcsp_pkg::ADDR_ERRORS, 8'h40);
    i_host.acc(1'b1, rcsp_pkg::ADDR_CONTROL, 8'hFF);
    rd(rcsp_pkg::ADDR_CONTROL, 8'h30);
    i_host.acc(1'b1, rcsp_pkg::ADDR_CONTROL, 8'h00);
    clash = 8'($urandom % 9);
    evt_lvl.clash_pos = clash;
    evt_lvl.receive_checksum_check_enable = 1'b1;
    for (int i = 0; i < 12; i++) begin
      ev(bt[i]);
      rd(i == 11 ? rcsp_pkg::ADDR_CONTROL : rcsp_pkg::ADDR_ERRORS, ex[i]);
      if (bt[i] == 11) rd(rcsp_pkg::ADDR_CLASH, clash);
      if (bt[i] == 17) begin
        i_host.acc(1'b1, rcsp_pkg::ADDR_CONTROL, 8'h01);
        rd(rcsp_pkg::ADDR_ERRORS, 8'h00);
      end
    end
    ev(0);
    rd(rcsp_pkg::ADDR_CONTROL, 8'h00);
    evt_lvl.type_b_mode = 1'b1;
    evt_lvl.clash_pos = ~clash;
    ev(11);
    rd(rcsp_pkg::ADDR_ERRORS, 8'h00);
    rd(rcsp_pkg::ADDR_CLASH, clash);
    repeat (4) @(negedge clk_sys);
    check("clash_index", clash_out, clash);
    complete_run;
  end
endmodule
